// File: drm_pkg.sv
// shared constants and types of the drive monitoring readback bank
package drm_pkg;
    // parameter indices of the monitoring values
    localparam logic [7:0] DRM_IDX_CAP_A = 8'h61;
    localparam logic [7:0] DRM_IDX_CAP_B = 8'h62;
    localparam logic [7:0] DRM_IDX_CAP_C = 8'h63;
    localparam logic [7:0] DRM_IDX_MOTOR_TEMP = 8'h84;
    localparam logic [7:0] DRM_IDX_THERM_OHMS = 8'h85;
    localparam logic [7:0] DRM_IDX_IN_IMAGE = 8'h8a;
    localparam logic [7:0] DRM_IDX_OUT_IMAGE = 8'h8b;
    // field layout
    localparam int DRM_CAP_CHANNELS = 3;
    localparam int DRM_IO_MAX = 16;
    localparam int DRM_TEMP_FRAC_BITS = 16;
    localparam int DRM_OHMS_WIDTH = 16;
    // reset values
    localparam logic [31:0] DRM_RESET_WORD = 32'h0;
    localparam logic [15:0] DRM_RESET_HALF = 16'h0;
    // operating modes, gray coded
    typedef enum logic [1:0] {
        DRM_MODE_CURRENT = 2'h0,
        DRM_MODE_VELOCITY = 2'h1,
        DRM_MODE_POSITION = 2'h3
    } drm_mode_e;
endpackage

// File: drm_cap_if.sv
// capture sources and operating mode shared by the capture channels
`timescale 1ns/1ps
interface drm_cap_if;
    logic [1:0] mode;
    logic [31:0] current_unit_scale;
    logic [31:0] velocity_unit_scale;
    logic [31:0] position_counts;
    modport src (output mode, current_unit_scale, velocity_unit_scale, position_counts);
    modport cap (input mode, current_unit_scale, velocity_unit_scale, position_counts);
endinterface

// File: drm_capture_chan.sv
// one capture channel: latches the mode-selected source on its strobe
`timescale 1ns/1ps
module drm_capture_chan
    import drm_pkg::*;
(
    input wire logic clk_i,         // 10 MHz clock
    input wire logic reset_n_i,     // async reset, active low
    drm_cap_if.cap bus,             // sources and mode
    input wire logic strobe_i,      // capture event
    output logic [31:0] value_o     // captured result
);
    typedef struct packed {
        logic [31:0] value;
    } drm_chan_s;

    drm_chan_s st_r;
    drm_chan_s st_nxt;

    // pick the unit that matches the mode; an illegal mode keeps the old value
    always_comb begin
        st_nxt = st_r;
        if (strobe_i) begin
            unique case (bus.mode)
                DRM_MODE_CURRENT: st_nxt.value = bus.current_unit_scale;
                DRM_MODE_VELOCITY: st_nxt.value = bus.velocity_unit_scale;
                DRM_MODE_POSITION: st_nxt.value = bus.position_counts;
                default: st_nxt.value = st_r.value;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_r <= '{value: DRM_RESET_WORD};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign value_o = st_r.value;
endmodule

// File: drm_monitor.sv
// drive monitoring readback bank: temperature, thermistor, captures, i/o images
// What this block does
// RULE_01: motor temperature is a signed 32-bit read-only value, never stored.
// RULE_02: temperature reported with 16 fraction bits, value/65536 gives Celsius.
// RULE_03: thermistor resistance in ohms, unsigned 16 bits, when hardware has it.
// RULE_04: captures take current, velocity or position-count units by mode.
// RULE_05: three independent signed 32-bit capture results A, B and C.
// RULE_06: input image bit n is input n+1, after active-level handling.
// RULE_07: output image bit n is output n+1, before active-level handling.
// RULE_08: only the inputs the model has are populated, at most 16.
// RULE_09: only the outputs the model has are populated, at most 16.
// RULE_10: bits of absent channels read as zero.
// RULE_11: writes to these values change nothing.
`timescale 1ns/1ps
module drm_monitor
    import drm_pkg::*;
#(
    parameter int NUM_INPUTS = 16,      // inputs fitted on this model
    parameter int NUM_OUTPUTS = 16,     // outputs fitted on this model
    parameter bit THERM_SUPPORTED = 1'b1 // thermistor measurement fitted
) (
    input wire logic clk_i,                        // 10 MHz clock
    input wire logic reset_n_i,                    // async reset, active low
    input wire logic req_i,                        // parameter access request
    input wire logic write_i,                      // 1 = write attempt
    input wire logic [7:0] index_i,                // parameter index
    input wire logic [31:0] wdata_i,               // write data, never stored
    output logic ack_o,                            // answer pulse
    output logic err_o,                            // refused or unmapped
    output logic [31:0] rdata_o,                   // read data
    input wire logic [31:0] motor_temp_i,          // sensed temp, 16 fraction bits
    input wire logic [15:0] therm_ohms_i,          // thermistor resistance
    input wire logic [1:0] mode_i,                 // operating mode
    input wire logic [31:0] current_unit_scale_i,  // source in current units
    input wire logic [31:0] velocity_unit_scale_i, // source in velocity units
    input wire logic [31:0] position_counts_i,     // source in encoder counts
    input wire logic [2:0] capture_strobe_i,       // capture events A, B, C
    input wire logic [15:0] din_raw_i,             // raw digital input pins
    input wire logic [15:0] din_active_low_i,      // per input: active low
    input wire logic [15:0] dout_cmd_i             // commanded outputs, pre level
);
    // refuse models with more channels than the image holds
    if (NUM_INPUTS < 0 || NUM_INPUTS > DRM_IO_MAX || NUM_OUTPUTS < 0
        || NUM_OUTPUTS > DRM_IO_MAX) begin : g_bad_io
        $error("drm_monitor: channel count out of range");
    end

    localparam logic [31:0] IN_MASK32 = (32'h1 << NUM_INPUTS) - 32'h1;
    localparam logic [31:0] OUT_MASK32 = (32'h1 << NUM_OUTPUTS) - 32'h1;
    localparam logic [15:0] IN_MASK = IN_MASK32[15:0];
    localparam logic [15:0] OUT_MASK = OUT_MASK32[15:0];

    typedef struct packed {
        logic ack;
        logic err;
        logic [31:0] rdata;
        logic [31:0] temp;
        logic [15:0] ohms;
        logic [15:0] din;
        logic [15:0] dout;
    } drm_top_s;

    drm_top_s st_r;
    drm_top_s st_nxt;
    logic [31:0] cap_val [DRM_CAP_CHANNELS];
    logic [15:0] unused_wdata;

    drm_cap_if cap_bus ();

    // sources for the capture channels
    assign cap_bus.mode = mode_i;
    assign cap_bus.current_unit_scale = current_unit_scale_i;
    assign cap_bus.velocity_unit_scale = velocity_unit_scale_i;
    assign cap_bus.position_counts = position_counts_i;
    // write data is discarded on purpose: every value here is read-only
    assign unused_wdata = wdata_i[15:0] & wdata_i[31:16];

    // RULE_05: three capture channels
    for (genvar c = 0; c < DRM_CAP_CHANNELS; c++) begin : g_cap
        drm_capture_chan u_chan (
            .clk_i(clk_i),
            .reset_n_i(reset_n_i),
            .bus(cap_bus),
            .strobe_i(capture_strobe_i[c]),
            .value_o(cap_val[c])
        );
    end

    // next state: live snapshots plus the access answer
    always_comb begin
        st_nxt = st_r;
        // RULE_01: temperature snapshot, volatile
        // RULE_02: fixed point passes through unchanged
        st_nxt.temp = motor_temp_i;
        // RULE_03: ohms only where fitted
        st_nxt.ohms = THERM_SUPPORTED ? therm_ohms_i : DRM_RESET_HALF;
        // RULE_06: inputs after active level
        // RULE_08: masked to fitted inputs
        st_nxt.din = (din_raw_i ^ din_active_low_i) & IN_MASK;
        // RULE_07: outputs before active level
        // RULE_09: masked to fitted outputs
        st_nxt.dout = dout_cmd_i & OUT_MASK;
        st_nxt.ack = req_i;
        st_nxt.err = 1'b0;
        st_nxt.rdata = DRM_RESET_WORD;
        if (req_i) begin
            // RULE_11: writes refused, nothing stored
            if (write_i) begin
                st_nxt.err = 1'b1;
            end else begin
                unique case (index_i)
                    DRM_IDX_CAP_A: st_nxt.rdata = cap_val[0];
                    DRM_IDX_CAP_B: st_nxt.rdata = cap_val[1];
                    DRM_IDX_CAP_C: st_nxt.rdata = cap_val[2];
                    DRM_IDX_MOTOR_TEMP: st_nxt.rdata = st_r.temp;
                    DRM_IDX_THERM_OHMS: st_nxt.rdata = {16'h0, st_r.ohms};
                    // RULE_10: narrow images zero-extended
                    DRM_IDX_IN_IMAGE: st_nxt.rdata = {16'h0, st_r.din};
                    DRM_IDX_OUT_IMAGE: st_nxt.rdata = {16'h0, st_r.dout};
                    default: st_nxt.err = 1'b1;
                endcase
            end
        end
    end

    // state register
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_r <= '{ack: 1'b0, err: 1'b0, rdata: DRM_RESET_WORD, temp: DRM_RESET_WORD,
                      ohms: DRM_RESET_HALF, din: DRM_RESET_HALF, dout: DRM_RESET_HALF};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ack_o = st_r.ack;
    assign err_o = st_r.err;
    assign rdata_o = st_r.rdata;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_read(logic [7:0] idx);
        req_i && !write_i && index_i == idx;
    endsequence

    sequence s_good_answer;
        ack_o && !err_o;
    endsequence

    sequence s_quiet_write;
        req_i && write_i && capture_strobe_i == 3'h0;
    endsequence

    AST_TEMP_READ: assert property ( // RULE_01
        s_read(DRM_IDX_MOTOR_TEMP) |=> s_good_answer ##0 rdata_o == $past(st_r.temp))
        else $error("temperature read answer wrong");

    // snapshots follow their inputs one edge late; the sampled reset keeps the
    // first edge after a release out of the $past comparisons
    AST_TEMP_FORMAT: assert property ( // RULE_02
        reset_n_i |=> st_r.temp == $past(motor_temp_i) ##1 st_r.temp == $past(motor_temp_i))
        else $error("temperature fixed point altered");

    AST_OHMS_READ: assert property ( // RULE_03
        s_read(DRM_IDX_THERM_OHMS) |=> s_good_answer ##0 rdata_o[31:16] == 16'h0
        ##0 rdata_o[15:0] == (THERM_SUPPORTED ? $past(st_r.ohms) : 16'h0))
        else $error("thermistor read wrong");

    // capture channels: each latches the source that matches the mode
    AST_CAP_MODE: assert property ( // RULE_04
        capture_strobe_i[0] && mode_i == DRM_MODE_CURRENT
        |=> cap_val[0] == $past(current_unit_scale_i))
        else $error("capture mode unit wrong");

    AST_CAP_INDEPENDENT: assert property ( // RULE_05
        capture_strobe_i == 3'h2 && mode_i == DRM_MODE_VELOCITY
        |=> cap_val[1] == $past(velocity_unit_scale_i) && $stable(cap_val[0])
        && $stable(cap_val[2]))
        else $error("capture channels not independent");

    AST_IN_IMAGE: assert property ( // RULE_06
        s_read(DRM_IDX_IN_IMAGE) |-> ##1 st_r.din == $past((din_raw_i ^ din_active_low_i)
        & IN_MASK) ##0 rdata_o == {16'h0, $past(st_r.din)})
        else $error("input image wrong");

    AST_OUT_IMAGE: assert property ( // RULE_07
        reset_n_i |=> st_r.dout == ($past(dout_cmd_i) & OUT_MASK))
        else $error("output image wrong");

    AST_ABSENT_ZERO: assert property ( // RULE_10
        (st_r.din & ~IN_MASK) == 16'h0 && (st_r.dout & ~OUT_MASK) == 16'h0)
        else $error("absent channel bit set");

    // count checks skip the release edge, where the snapshot still holds zero
    AST_IN_COUNT: assert property ( // RULE_08
        reset_n_i && din_raw_i == ~din_active_low_i |=> st_r.din == IN_MASK)
        else $error("fitted inputs not populated");

    AST_OUT_COUNT: assert property ( // RULE_09
        reset_n_i && dout_cmd_i == 16'hffff |=> st_r.dout == OUT_MASK)
        else $error("fitted outputs not populated");

    AST_WRITE_REFUSED: assert property ( // RULE_11
        s_quiet_write
        |=> ack_o && err_o && rdata_o == 32'h0 && $stable(cap_val[0])
        && $stable(cap_val[1]) && $stable(cap_val[2]))
        else $error("write not refused");

    AST_CAP_POSITION: assert property ( // RULE_04
        capture_strobe_i[2] && mode_i == DRM_MODE_POSITION
        |=> cap_val[2] == $past(position_counts_i))
        else $error("capture position counts wrong");

    // an illegal mode code must not disturb a held capture
    AST_CAP_ILLEGAL_HOLD: assert property ( // RULE_04
        capture_strobe_i[0] && mode_i == 2'h2 |=> $stable(cap_val[0]))
        else $error("capture changed on illegal mode");

    AST_CAP_READ: assert property ( // RULE_05
        s_read(DRM_IDX_CAP_B) |=> s_good_answer ##0 rdata_o == $past(cap_val[1]))
        else $error("capture read answer wrong");

    AST_OUT_READ: assert property ( // RULE_07
        s_read(DRM_IDX_OUT_IMAGE) |=> s_good_answer ##0 rdata_o == {16'h0, $past(st_r.dout)})
        else $error("output image read wrong");
endmodule

// File: drm_master_model.sv
// partner model: network master issuing parameter accesses
`timescale 1ns/1ps
module drm_master_model (
    input wire logic clk_i,     // bench clock
    output logic req_o,         // access request
    output logic write_o,       // write attempt
    output logic [7:0] index_o, // parameter index
    output logic [31:0] wdata_o // write data
);
    // idle bus at time zero
    initial begin
        req_o = 1'b0;
        write_o = 1'b0;
        index_o = 8'h00;
        wdata_o = 32'h0;
    end

    // one access per call, held until the next edge; call just after an edge
    task automatic access(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        req_o <= 1'b1;
        write_o <= wr;
        index_o <= idx;
        wdata_o <= wd;
        @(posedge clk_i);
    endtask

    // released lines flip so a stale value is never mistaken for a live one
    task automatic release_bus();
        req_o <= 1'b0;
        write_o <= ~write_o;
        index_o <= ~index_o;
        wdata_o <= ~wdata_o;
        @(posedge clk_i);
    endtask
endmodule

// File: test_drive_monitor_readback.sv
// self-checking bench for the monitoring readback bank
`timescale 1ns/1ps
module test_drive_monitor_readback;
    import drm_pkg::*;
    logic clk_i, reset_n_i, req, wr, ack, err;
    logic [7:0] idx;
    logic [31:0] wd, rdata, temp, cur, vel, pos;
    logic [15:0] ohms, raw, al, dcmd, rr;
    logic [1:0] mode;
    logic [2:0] strobe;
    logic [32:0] exp_q[$];
    logic [31:0] capv[3];
    drm_mode_e md[3] = '{DRM_MODE_CURRENT, DRM_MODE_VELOCITY, DRM_MODE_POSITION};
    int miscompares = 0, tests_run = 0, seed = 32'h9d0691f4;

    drm_master_model drm_master_model_inst (.clk_i(clk_i), .req_o(req), .write_o(wr),
        .index_o(idx), .wdata_o(wd));
    // fewer channels than the maximum so absent bits are exercised
    drm_monitor #(.NUM_INPUTS(12), .NUM_OUTPUTS(10), .THERM_SUPPORTED(1'b1)) drm_monitor_inst (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .req_i(req), .write_i(wr), .index_i(idx),
        .wdata_i(wd), .ack_o(ack), .err_o(err), .rdata_o(rdata), .motor_temp_i(temp),
        .therm_ohms_i(ohms), .mode_i(mode), .current_unit_scale_i(cur),
        .velocity_unit_scale_i(vel), .position_counts_i(pos), .capture_strobe_i(strobe),
        .din_raw_i(raw), .din_active_low_i(al), .dout_cmd_i(dcmd));

    // 10 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic compare(input logic [32:0] exp, input logic [32:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    // note the expected answer, then issue the access
    task automatic acc(input logic w, input logic [7:0] i, input logic e, input logic [31:0] d);
        exp_q.push_back({e, d});
        drm_master_model_inst.access(w, i, $random(seed));
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // bounded drain of outstanding notes
    task automatic drain();
        for (int k = 0; k < 10 && exp_q.size() != 0; k++) @(posedge clk_i);
        if (exp_q.size() != 0) miscompares++;
    endtask

    // every answer pulse retires the oldest note
    always @(posedge clk_i) begin
        if (ack === 1'b1) begin
            if (exp_q.size() == 0) begin
                miscompares++;
                $display("ERROR t=%0t exp=none got=%h", $time, {err, rdata});
            end else begin
                compare(exp_q.pop_front(), {err, rdata});
            end
        end
    end

    // hang guard
    initial begin
        repeat (5000) @(posedge clk_i);
        miscompares++;
        print_verdict();
    end

    initial begin
        {reset_n_i, temp, ohms, mode, cur, vel, pos, strobe, raw, al, dcmd} = '0;
        repeat (6) @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(posedge clk_i);
        // random snapshots, settled for three cycles before back-to-back reads;
        // the last pass drives every fitted channel active to reach the count checks
        for (int n = 0; n < 5; n++) begin
            rr = 16'($random(seed));
            temp <= $random(seed);
            ohms <= 16'($random(seed));
            raw <= rr;
            al <= (n == 4) ? ~rr : 16'($random(seed));
            dcmd <= (n == 4) ? 16'hffff : 16'($random(seed));
            repeat (3) @(posedge clk_i);
            acc(1'b0, DRM_IDX_MOTOR_TEMP, 1'b0, temp);
            acc(1'b0, DRM_IDX_THERM_OHMS, 1'b0, {16'h0, ohms});
            acc(1'b0, DRM_IDX_IN_IMAGE, 1'b0, {16'h0, (raw ^ al) & 16'h0fff});
            acc(1'b0, DRM_IDX_OUT_IMAGE, 1'b0, {16'h0, dcmd & 16'h03ff});
            drm_master_model_inst.release_bus();
        end
        // each channel captured in its own mode, then sources move on
        for (int c = 0; c < 3; c++) begin
            mode <= md[c];
            cur <= $random(seed);
            vel <= $random(seed);
            pos <= $random(seed);
            strobe <= 3'h1 << c;
            @(posedge clk_i);
            capv[c] = (md[c] == DRM_MODE_CURRENT) ? cur : (md[c] == DRM_MODE_VELOCITY) ? vel : pos;
            strobe <= 3'h0;
            cur <= ~cur;
            vel <= ~vel;
            pos <= ~pos;
            repeat (2) @(posedge clk_i);
        end
        // illegal mode code with a strobe: channel A keeps its value
        mode <= 2'h2;
        cur <= $random(seed);
        strobe <= 3'h1;
        @(posedge clk_i);
        strobe <= 3'h0;
        @(posedge clk_i);
        acc(1'b0, DRM_IDX_CAP_A, 1'b0, capv[0]);
        acc(1'b0, DRM_IDX_CAP_B, 1'b0, capv[1]);
        acc(1'b0, DRM_IDX_CAP_C, 1'b0, capv[2]);
        acc(1'b1, DRM_IDX_CAP_A, 1'b1, 32'h0);
        acc(1'b1, DRM_IDX_MOTOR_TEMP, 1'b1, 32'h0);
        acc(1'b0, DRM_IDX_CAP_A, 1'b0, capv[0]);
        acc(1'b0, DRM_IDX_MOTOR_TEMP, 1'b0, temp);
        acc(1'b0, 8'h00, 1'b1, 32'h0);
        drm_master_model_inst.release_bus();
        drain();
        // mid-run reset: captures return to zero, snapshots reload from live inputs
        reset_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(posedge clk_i);
        acc(1'b0, DRM_IDX_CAP_A, 1'b0, 32'h0);
        acc(1'b0, DRM_IDX_MOTOR_TEMP, 1'b0, temp);
        drm_master_model_inst.release_bus();
        drain();
        print_verdict();
    end
endmodule
